/* File: acs_pkg.sv */
// shared constants and types for the actuator coarse seek controller
package acs_pkg;

    // ========================================================
    // clock and timing
    localparam int CLK_MHZ = 100;
    localparam int STEP_GAP_US = 200;
    localparam int STEP_WIDE_US = 1500;
    localparam int FAST_TRACK_US = 20;
    localparam int SLOW_TRACK_US = 40;
    localparam int PWRUP_US = 10;
    localparam int STEP_GAP_CYC = STEP_GAP_US * CLK_MHZ;
    localparam int STEP_WIDE_CYC = STEP_WIDE_US * CLK_MHZ;
    localparam logic [15:0] FAST_TRACK_CYC = 16'(FAST_TRACK_US * CLK_MHZ);
    localparam logic [15:0] SLOW_TRACK_CYC = 16'(SLOW_TRACK_US * CLK_MHZ);
    localparam logic [15:0] PWRUP_CYC = 16'(PWRUP_US * CLK_MHZ);

    // ========================================================
    // seek classification and angle
    localparam logic [10:0] SLEW_MIN_STEPS = 11'h007;
    localparam logic [10:0] ANGLE_ZONE = 11'h003;
    localparam logic [7:0] QUARTER = 8'h40;
    localparam logic [7:0] HALF_QUARTER = 8'h20;

    // ========================================================
    // actuator current codes, offset binary
    localparam logic [7:0] CODE_FULL_OUT = 8'hFF;
    localparam logic [7:0] CODE_ZERO = 8'h80;
    localparam logic [7:0] CODE_FULL_IN = 8'h00;

    // ========================================================
    // register map (word index on reg_addr)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_ANGLE = 4'h2;
    localparam logic [3:0] REG_REMAIN = 4'h3;
    localparam int CTRL_PWR_ALLOW = 0;
    localparam logic [15:0] CTRL_RESET = 16'h0001;

    typedef enum logic [2:0] {
        ST_PWRUP, ST_IDLE, ST_COLLECT, ST_SLEW_ACC, ST_SLEW_DEC, ST_STEP, ST_FINE
    } acs_state_t;

    typedef struct packed {
        logic [6:0] rsvd;
        logic power_en;
        logic settled;
        logic angle_mode;
        logic single_chan;
        logic dir_inward;
        logic slew;
        acs_state_t state;
    } acs_status_t;

endpackage

/* File: acs_coarse_seek.sv */
// coarse seek, track counting, angle settling and actuator drive control
// ========================================================
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module acs_coarse_seek #(
    parameter logic [17:0] GAP_CYC = 18'(acs_pkg::STEP_GAP_CYC),
    parameter logic [17:0] WIDE_CYC = 18'(acs_pkg::STEP_WIDE_CYC)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic step_pulse,
    input wire logic step_dir_inward,
    input wire logic sample_valid,
    input wire logic signed [7:0] track_phase_first,
    input wire logic signed [7:0] track_phase_second,
    input wire logic fine_done,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [7:0] act_code,
    output logic act_power_en,
    output logic comp_enable,
    output logic coarse_seek,
    output logic fine_request,
    output logic settled_n
);

    // ========================================================
    // helper functions
    function automatic logic [7:0] mag(input logic signed [7:0] v);
        mag = v[7] ? 8'(-v) : 8'(v);
    endfunction

    // quadrant from signs, position inside it from the magnitude difference;
    // cheap stand-in for arctan that relies on the gain loop keeping amplitude steady
    function automatic logic [7:0] angle_of(input logic signed [7:0] a, input logic signed [7:0] b);
        logic signed [9:0] d;
        logic signed [9:0] f;
        logic [7:0] base;
        d = 10'sd0;
        base = 8'h00;
        case ({a[7], b[7]})
            2'b00: begin
                base = 8'h00;
                d = $signed({2'b00, mag(b)}) - $signed({2'b00, mag(a)});
            end
            2'b10: begin
                base = acs_pkg::QUARTER;
                d = $signed({2'b00, mag(a)}) - $signed({2'b00, mag(b)});
            end
            2'b11: begin
                base = 8'(2 * acs_pkg::QUARTER);
                d = $signed({2'b00, mag(b)}) - $signed({2'b00, mag(a)});
            end
            default: begin
                base = 8'(3 * acs_pkg::QUARTER);
                d = $signed({2'b00, mag(a)}) - $signed({2'b00, mag(b)});
            end
        endcase
        f = $signed({2'b00, acs_pkg::HALF_QUARTER}) + (d >>> 2);
        if (f > 10'sd63) begin
            f = 10'sd63;
        end
        angle_of = base + 8'(f);
    endfunction

    // angle error to current: positive error means too far inward, so push outward
    function automatic logic [7:0] drive_of(input logic signed [7:0] e);
        logic signed [8:0] s;
        s = {e, 1'b0};
        if (s > 9'sd127) begin
            s = 9'sd127;
        end
        if (s < -9'sd128) begin
            s = -9'sd128;
        end
        drive_of = 8'(s + 9'sd128);
    endfunction

    function automatic logic [10:0] sat_sub(input logic [10:0] v, input logic [10:0] n);
        sat_sub = (v > n) ? v - n : 11'h000;
    endfunction

    // ========================================================
    // state
    acs_pkg::acs_state_t state_q, state_d;
    logic [15:0] ctrl_q;
    logic [15:0] pwr_cnt_q;
    logic step_prev_q;
    logic [17:0] gap_cnt_q;
    logic [17:0] width_cnt_q;
    logic [10:0] step_cnt_q;
    logic dir_q;
    logic [10:0] remain_q;
    logic [10:0] half_q;
    logic [10:0] travel_q;
    logic single_chan_q;
    logic [15:0] intvl_q;
    logic slew_q;
    logic angle_mode_q;
    logic signed [7:0] prev_first_q;
    logic signed [7:0] prev_second_q;
    logic [7:0] angle_q;
    logic [7:0] ref_q;
    logic [7:0] act_code_q;
    logic power_en_q;
    logic comp_en_q;
    logic coarse_q;
    logic fine_req_q;
    logic settled_n_q;
    logic [15:0] rdata_q;

    // ========================================================
    // step pulse classification
    wire step_rise = step_pulse && !step_prev_q;
    wire step_fall = !step_pulse && step_prev_q;
    wire accept = (state_q == acs_pkg::ST_IDLE) || (state_q == acs_pkg::ST_COLLECT);
    wire lone_wide = step_fall && (step_cnt_q == 11'h001) && (width_cnt_q >= WIDE_CYC);
    wire burst_end = !step_pulse && (gap_cnt_q >= GAP_CYC) && !lone_wide;
    wire go_slew = burst_end && (step_cnt_q >= acs_pkg::SLEW_MIN_STEPS);
    wire go_single = lone_wide || (burst_end && !go_slew);

    // ========================================================
    // track crossings from sample sign changes
    wire zc_first = sample_valid && (track_phase_first[7] != prev_first_q[7]);
    wire zc_second = sample_valid && (track_phase_second[7] != prev_second_q[7]);
    wire slew_run = (state_q == acs_pkg::ST_SLEW_ACC) || (state_q == acs_pkg::ST_SLEW_DEC);
    // each crossing of either phase is one track; first phase alone is every other track
    wire count_both = !single_chan_q && (zc_first || zc_second);
    wire count_one = single_chan_q && zc_first;
    wire counted = slew_run && (count_both || count_one);
    wire [10:0] dec_by = single_chan_q ? 11'h002 : 11'h001;
    wire [10:0] remain_next = counted ? sat_sub(remain_q, dec_by) : remain_q;
    wire [10:0] travel_next = counted ? travel_q + dec_by : travel_q;
    wire to_fast = counted && !single_chan_q && (state_q == acs_pkg::ST_SLEW_ACC)
        && (intvl_q < acs_pkg::FAST_TRACK_CYC);
    // in deceleration a slowing arm or a near target falls back to single-track resolution; near_target does so in both slew states unless to_fast fires too
    wire to_slow = single_chan_q && (state_q == acs_pkg::ST_SLEW_DEC)
        && ((intvl_q > acs_pkg::SLOW_TRACK_CYC) || (remain_q <= 11'h004));
    wire half_done = travel_next >= half_q;
    wire near_target = remain_next <= acs_pkg::ANGLE_ZONE;

    // ========================================================
    // angle regulation
    wire [7:0] angle_now = angle_of(track_phase_first, track_phase_second);
    wire signed [7:0] ang_err = $signed(angle_q - ref_q);
    // done on reaching zero or on passing it between samples
    wire step_reached = dir_q ? !ang_err[7] : ((ang_err == 8'sh00) || ang_err[7]);
    wire [7:0] ref_next = dir_q ? angle_q + acs_pkg::QUARTER : angle_q - acs_pkg::QUARTER;
    // angle mode lines the start up on the nearest track center
    wire [7:0] aligned = (angle_q + acs_pkg::HALF_QUARTER) & ~(acs_pkg::QUARTER - 8'h01);
    wire [7:0] ref_align = dir_q ? aligned + acs_pkg::QUARTER : aligned - acs_pkg::QUARTER;
    wire [7:0] full_code = dir_q ? acs_pkg::CODE_FULL_IN : acs_pkg::CODE_FULL_OUT;
    wire [7:0] rev_code = dir_q ? acs_pkg::CODE_FULL_OUT : acs_pkg::CODE_FULL_IN;

    // ========================================================
    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            acs_pkg::ST_PWRUP: begin
                if (pwr_cnt_q >= acs_pkg::PWRUP_CYC) begin
                    state_d = acs_pkg::ST_IDLE;
                end
            end
            acs_pkg::ST_IDLE: begin
                if (step_rise) begin
                    state_d = acs_pkg::ST_COLLECT;
                end
            end
            acs_pkg::ST_COLLECT: begin
                if (go_slew) begin
                    state_d = acs_pkg::ST_SLEW_ACC;
                end else if (go_single) begin
                    state_d = acs_pkg::ST_STEP;
                end
            end
            acs_pkg::ST_SLEW_ACC: begin
                if (near_target) begin
                    state_d = acs_pkg::ST_STEP;
                end else if (half_done) begin
                    state_d = acs_pkg::ST_SLEW_DEC;
                end
            end
            acs_pkg::ST_SLEW_DEC: begin
                if (near_target) begin
                    state_d = acs_pkg::ST_STEP;
                end
            end
            acs_pkg::ST_STEP: begin
                if (remain_q == 11'h000) begin
                    state_d = acs_pkg::ST_FINE;
                end
            end
            acs_pkg::ST_FINE: begin
                if (step_rise) begin
                    state_d = acs_pkg::ST_COLLECT;
                end
            end
            default: state_d = acs_pkg::ST_IDLE;
        endcase
    end

    // ========================================================
    // output decode
    wire seeking = slew_run || (state_q == acs_pkg::ST_STEP) || (state_q == acs_pkg::ST_COLLECT);
    wire pwr_allow = ctrl_q[acs_pkg::CTRL_PWR_ALLOW];
    wire power_en_d = (state_q != acs_pkg::ST_PWRUP) && pwr_allow;
    wire [7:0] code_d = !power_en_d ? acs_pkg::CODE_ZERO
        : (state_d == acs_pkg::ST_SLEW_ACC) ? full_code
        : (state_d == acs_pkg::ST_SLEW_DEC) ? rev_code
        : (state_q == acs_pkg::ST_STEP && state_d == acs_pkg::ST_STEP) ? drive_of(ang_err)
        : acs_pkg::CODE_ZERO;
    wire fine_waiting = (state_q == acs_pkg::ST_FINE) && settled_n_q;
    wire settled_n_d = !((state_q == acs_pkg::ST_FINE) && (fine_done || !settled_n_q)
        && (state_d == acs_pkg::ST_FINE));

    acs_pkg::acs_status_t status;
    assign status = '{rsvd: 7'h00, power_en: power_en_q, settled: !settled_n_q,
        angle_mode: angle_mode_q, single_chan: single_chan_q, dir_inward: dir_q,
        slew: slew_q, state: state_q};
    wire [15:0] rd_mux = (reg_addr == acs_pkg::REG_CTRL) ? ctrl_q
        : (reg_addr == acs_pkg::REG_STATUS) ? 16'(status)
        : (reg_addr == acs_pkg::REG_ANGLE) ? {angle_q, ref_q}
        : (reg_addr == acs_pkg::REG_REMAIN) ? {5'h00, remain_q}
        : 16'h0000;

    // ========================================================
    // step collection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            step_prev_q <= 1'b0;
            gap_cnt_q <= 18'h00000;
            width_cnt_q <= 18'h00000;
            step_cnt_q <= 11'h000;
            dir_q <= 1'b0;
        end else begin
            step_prev_q <= step_pulse;
            if (accept || state_q == acs_pkg::ST_FINE) begin
                if (step_rise) begin
                    // direction level at the latest step wins
                    dir_q <= step_dir_inward;
                    step_cnt_q <= (state_q == acs_pkg::ST_COLLECT) ? step_cnt_q + 11'h001 : 11'h001;
                    width_cnt_q <= 18'h00000;
                    gap_cnt_q <= 18'h00000;
                end else if (step_pulse) begin
                    width_cnt_q <= (width_cnt_q == 18'h3FFFF) ? width_cnt_q : width_cnt_q + 18'h00001;
                end else if (gap_cnt_q != 18'h3FFFF) begin
                    gap_cnt_q <= gap_cnt_q + 18'h00001;
                end
            end
        end
    end

    // ========================================================
    // seek progress
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= acs_pkg::ST_PWRUP;
            pwr_cnt_q <= 16'h0000;
            remain_q <= 11'h000;
            half_q <= 11'h000;
            travel_q <= 11'h000;
            single_chan_q <= 1'b0;
            intvl_q <= 16'h0000;
            slew_q <= 1'b0;
            angle_mode_q <= 1'b0;
            ref_q <= 8'h00;
        end else begin
            state_q <= state_d;
            if (state_q == acs_pkg::ST_PWRUP) begin
                pwr_cnt_q <= pwr_cnt_q + 16'h0001;
            end
            intvl_q <= counted ? 16'h0000 : ((intvl_q == 16'hFFFF) ? intvl_q : intvl_q + 16'h0001);
            if (state_q == acs_pkg::ST_COLLECT && state_d != acs_pkg::ST_COLLECT) begin
                remain_q <= step_cnt_q;
                half_q <= step_cnt_q >> 1;
                travel_q <= 11'h000;
                single_chan_q <= 1'b0;
                slew_q <= go_slew;
                angle_mode_q <= 1'b0;
                ref_q <= ref_next;
            end else if (slew_run) begin
                remain_q <= remain_next;
                travel_q <= travel_next;
                if (to_fast) begin
                    single_chan_q <= 1'b1;
                end else if (to_slow || near_target) begin
                    single_chan_q <= 1'b0;
                end
                if (near_target) begin
                    angle_mode_q <= 1'b1;
                    ref_q <= ref_align;
                end
            end else if (state_q == acs_pkg::ST_STEP && remain_q != 11'h000 && step_reached) begin
                // each finished quarter loads the next reference until none remain
                remain_q <= remain_q - 11'h001;
                ref_q <= ref_next;
            end
        end
    end

    // ========================================================
    // samples, registers and outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_first_q <= 8'sh00;
            prev_second_q <= 8'sh00;
            angle_q <= 8'h00;
            ctrl_q <= acs_pkg::CTRL_RESET;
            rdata_q <= 16'h0000;
            act_code_q <= acs_pkg::CODE_ZERO;
            power_en_q <= 1'b0;
            comp_en_q <= 1'b0;
            coarse_q <= 1'b0;
            fine_req_q <= 1'b0;
            settled_n_q <= 1'b1;
        end else begin
            if (sample_valid) begin
                prev_first_q <= track_phase_first;
                prev_second_q <= track_phase_second;
                angle_q <= angle_now;
            end
            if (reg_wr && reg_addr == acs_pkg::REG_CTRL) begin
                ctrl_q <= reg_wdata & acs_pkg::CTRL_RESET;
            end
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
            act_code_q <= code_d;
            power_en_q <= power_en_d;
            coarse_q <= seeking;
            comp_en_q <= !seeking && power_en_d;
            fine_req_q <= fine_waiting && !fine_done;
            settled_n_q <= settled_n_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign act_code = act_code_q;
    assign act_power_en = power_en_q;
    assign comp_enable = comp_en_q;
    assign coarse_seek = coarse_q;
    assign fine_request = fine_req_q;
    assign settled_n = settled_n_q;

endmodule

/* File: acs_coarse_seek_properties.sv */
// checker with port-level properties of the coarse seek controller
`timescale 1ns/1ps
module acs_coarse_seek_properties #(
    parameter logic [17:0] GAP_CYC = 18'h04E20,
    parameter logic [17:0] WIDE_CYC = 18'h249F0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic step_pulse,
    input wire logic step_dir_inward,
    input wire logic sample_valid,
    input wire logic signed [7:0] track_phase_first,
    input wire logic signed [7:0] track_phase_second,
    input wire logic fine_done,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [7:0] act_code,
    input wire logic act_power_en,
    input wire logic comp_enable,
    input wire logic coarse_seek,
    input wire logic fine_request,
    input wire logic settled_n
);
    // ========================================
    // helpers
    logic [10:0] up_q;
    logic [10:0] up_d;
    // cycles since reset release, saturating so it never wraps into the early window
    assign up_d = (up_q == 11'h7FF) ? up_q : up_q + 11'h001;
    always_ff @(posedge clk) begin
        up_q <= sys_rst ? 11'h000 : up_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence step_from_idle;
        $rose(step_pulse) && act_power_en && !coarse_seek && !fine_request;
    endsequence
    sequence fine_answer;
        fine_request && fine_done;
    endsequence
    // ========================================
    // properties
    reset_quiet_a: assert property (disable iff (1'b0)
        sys_rst |=> act_code == acs_pkg::CODE_ZERO && !act_power_en && !comp_enable
        && !coarse_seek && !fine_request && settled_n) else $error("outputs active after reset");
    comp_out_a: assert property (coarse_seek |-> !comp_enable)
        else $error("compensation in during coarse seek");
    pwr_wait_a: assert property (up_q < 11'h3DE |-> !act_power_en)
        else $error("power enabled too early");
    pwr_up_a: assert property (up_q == 11'h3F0 |-> act_power_en)
        else $error("power not enabled after power-up");
    idle_code_a: assert property ((!act_power_en) [*2] |-> act_code == acs_pkg::CODE_ZERO)
        else $error("current commanded while unpowered");
    seek_start_a: assert property (step_from_idle |-> ##[1:3] coarse_seek)
        else $error("step did not start a seek");
    settle_a: assert property (fine_answer |=> !settled_n && !fine_request)
        else $error("settled indication missing");
    settle_why_a: assert property ($fell(settled_n) |-> $past(fine_done) && !coarse_seek)
        else $error("settled without fine settling");
    handover_a: assert property ($rose(fine_request) |-> $past(coarse_seek) && !coarse_seek)
        else $error("fine request not after coarse seek");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    unmapped_a: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule
bind acs_coarse_seek acs_coarse_seek_properties #(.GAP_CYC(GAP_CYC), .WIDE_CYC(WIDE_CYC)) u_props (
    .clk(clk), .sys_rst(sys_rst), .step_pulse(step_pulse), .step_dir_inward(step_dir_inward),
    .sample_valid(sample_valid), .track_phase_first(track_phase_first),
    .track_phase_second(track_phase_second), .fine_done(fine_done), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .act_code(act_code), .act_power_en(act_power_en), .comp_enable(comp_enable),
    .coarse_seek(coarse_seek), .fine_request(fine_request), .settled_n(settled_n));

/* File: acs_ctrl_model.sv */
// disk controller model: step bursts with a held direction level
`timescale 1ns/1ps
module acs_ctrl_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [3:0] steps,
    input wire logic [8:0] high_cyc,
    input wire logic dir_in,
    output logic step_pulse,
    output logic step_dir_inward,
    output logic busy
);
    logic [3:0] left_q = 4'h0;
    logic [8:0] cnt_q = 9'h000;
    initial begin
        step_pulse = 1'b0;
        step_dir_inward = 1'b0;
        busy = 1'b0;
    end
    // six low cycles keep a burst far inside the step gap
    always @(posedge clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            left_q <= steps;
            cnt_q <= 9'h000;
            step_dir_inward <= dir_in;
        end else if (busy) begin
            cnt_q <= cnt_q + 9'h001;
            step_pulse <= cnt_q < high_cyc;
            if (cnt_q == high_cyc + 9'h005) begin
                cnt_q <= 9'h000;
                left_q <= left_q - 4'h1;
                busy <= left_q != 4'h1;
            end
        end
    end
endmodule

/* File: actuator_coarse_seek_control_test.sv */
// self-checking bench for the actuator coarse seek controller
`timescale 1ns/1ps
module actuator_coarse_seek_control_test;
    localparam logic [17:0] GAP = 18'h00032;
    localparam logic [17:0] WIDE = 18'h000C8;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sample_valid = 1'b0;
    logic [2:0] sv_cnt = 3'h0;
    logic signed [7:0] ph1 = 8'sh40;
    logic signed [7:0] ph2 = 8'sh00;
    logic signed [7:0] xs [4] = '{8'sh28, 8'shD8, 8'shD8, 8'sh28};
    logic signed [7:0] ys [4] = '{8'sh28, 8'sh28, 8'shD8, 8'shD8};
    logic fine_done = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic start = 1'b0;
    logic [3:0] steps = 4'h1;
    logic [8:0] hi = 9'h004;
    logic dir_in = 1'b0;
    logic step_pulse, step_dir_inward, busy;
    logic [15:0] reg_rdata, outs, rd;
    logic [7:0] act_code;
    logic act_power_en, comp_enable, coarse_seek, fine_request, settled_n;
    int error_cnt = 0;
    int checks_done = 0;
    // bit 4 power, 3 compensation, 2 coarse seek, 1 fine request, 0 settled_n
    assign outs = {act_code, 3'h0, act_power_en, comp_enable, coarse_seek, fine_request, settled_n};
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        sv_cnt <= sv_cnt + 3'h1;
        sample_valid <= sv_cnt == 3'h7;
    end
    acs_coarse_seek #(.GAP_CYC(GAP), .WIDE_CYC(WIDE)) dut (
        .clk(clk), .sys_rst(sys_rst), .step_pulse(step_pulse), .step_dir_inward(step_dir_inward),
        .sample_valid(sample_valid), .track_phase_first(ph1), .track_phase_second(ph2),
        .fine_done(fine_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .act_code(act_code), .act_power_en(act_power_en),
        .comp_enable(comp_enable), .coarse_seek(coarse_seek), .fine_request(fine_request),
        .settled_n(settled_n));
    acs_ctrl_model ctrl (.clk(clk), .start(start), .steps(steps), .high_cyc(hi), .dir_in(dir_in),
        .step_pulse(step_pulse), .step_dir_inward(step_dir_inward), .busy(busy));
    // ========================================
    // shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_on(input int sel, input logic val, input int lim);
        for (int i = 0; i <= lim; i++) begin
            @(negedge clk);
            if (outs[sel] === val) return;
        end
        error_cnt++;
        $display("mismatch output bit %0d expected %b seen %b", sel, val, outs[sel]);
        report_and_stop();
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic burst(input logic [3:0] n, input logic [8:0] h, input logic d);
        @(posedge clk);
        steps <= n;
        hi <= h;
        dir_in <= d;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk);
            if (busy === 1'b0) return;
        end
        error_cnt++;
        $display("mismatch controller busy expected 0 seen 1");
        report_and_stop();
    endtask
    // ========================================
    // scenarios
    task automatic power_up();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        @(negedge clk);
        check("reset outputs", outs, 16'h8001);
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (980) @(posedge clk);
        @(negedge clk);
        check("power-up outputs", outs & 16'hFF17, 16'h8001);
        wait_on(4, 1'b1, 40);
        rdr(4'h1, rd);
        check("idle status", rd & 16'h0107, 16'h0101);
        repeat (20) @(posedge clk);
    endtask
    task automatic regs_test();
        rdr(4'h0, rd);
        check("ctrl reset", rd, 16'h0001);
        rdr(4'h9, rd);
        check("unmapped read", rd, 16'h0000);
        wr(4'h0, 16'hFFFE);
        wait_on(4, 1'b0, 4);
        @(negedge clk);
        check("unpowered code", outs & 16'hFF00, 16'h8000);
        rdr(4'h0, rd);
        check("ctrl cleared", rd, 16'h0000);
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'hFFFF);
        wait_on(4, 1'b1, 4);
        rdr(4'h0, rd);
        check("ctrl upper bits", rd, 16'h0001);
        rdr(4'h1, rd);
        check("status read-only", rd & 16'h0007, 16'h0001);
    endtask
    task automatic one_step(input logic d, input logic [8:0] h, input logic signed [7:0] p_end);
        burst(4'h1, h, d);
        check("comp in seek", outs & 16'h000C, 16'h0004);
        repeat (GAP + 10) @(posedge clk);
        @(negedge clk);
        check("step drive", outs & 16'hFF00, d ? 16'h0000 : 16'hFF00);
        rdr(4'h1, rd);
        check("step status", rd & 16'h001F, {11'h000, d, 4'h5});
        @(posedge clk);
        ph1 <= p_end;
        wait_on(1, 1'b1, 60);
        check("handover", outs & 16'h0004, 16'h0000);
        @(posedge clk);
        fine_done <= 1'b1;
        wait_on(0, 1'b0, 6);
        @(posedge clk);
        fine_done <= 1'b0;
        wait_on(3, 1'b1, 4);
    endtask
    task automatic slew_in();
        @(posedge clk);
        ph1 <= 8'sh28;
        ph2 <= 8'shD8;
        repeat (100) @(posedge clk);
        burst(4'h8, 9'h004, 1'b1);
        repeat (GAP + 10) @(posedge clk);
        @(negedge clk);
        check("slew accel", outs & 16'hFF0C, 16'h0004);
        // crossings closer than the fast interval: the third one must be ignored
        for (int k = 0; k < 4; k++) begin
            repeat (1500) @(posedge clk);
            ph1 <= xs[k];
            ph2 <= ys[k];
            repeat (20) @(posedge clk);
            @(negedge clk);
            check("slew drive", outs & 16'hFF00, k < 3 ? 16'h0000 : 16'hFF00);
            rdr(4'h3, rd);
            check("slew count", rd, k == 0 ? 16'h0007 : (k == 3 ? 16'h0004 : 16'h0006));
        end
        rdr(4'h1, rd);
        check("slew status", rd & 16'h003F, 16'h001C);
        rdr(4'h3, rd);
        check("tracks left", rd, 16'h0004);
    endtask
    initial begin
        power_up();
        regs_test();
        one_step(1'b1, 9'h004, 8'shC0);
        one_step(1'b0, 9'h0FA, 8'sh40);
        slew_in();
        power_up();
        report_and_stop();
    end
endmodule
